/* rtl/dacs_defines.svh */
// register offsets, field codes, command codes and reset values of the disk command sequencer
`ifndef DACS_DEFINES_SVH
`define DACS_DEFINES_SVH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define DACS_OFS_CMD 8'h00
`define DACS_OFS_STATUS 8'h04
`define DACS_OFS_CFA 8'h08
`define DACS_OFS_DFA 8'h0C
`define DACS_OFS_DCF0 8'h10
`define DACS_OFS_DCF9 8'h34

// ***************************************************************
// status bit positions
// ***************************************************************
`define DACS_ST_BUSY 0
`define DACS_ST_SEEK_BUSY 1
`define DACS_ST_REFUSED 2
`define DACS_ST_DATA_CHECK 3

// ***************************************************************
// command codes
// ***************************************************************
`define DACS_CMD_SEEK 3'h1
`define DACS_CMD_RECAL 3'h2
`define DACS_CMD_READ_HA 3'h3
`define DACS_CMD_READ_KD 3'h4
`define DACS_CMD_READ_CKD 3'h5
`define DACS_CMD_VERIFY 3'h6

// ***************************************************************
// drive field codes and control field layout
// ***************************************************************
`define DACS_FLD_HA 2'h0
`define DACS_FLD_CNT 2'h1
`define DACS_FLD_KD 2'h2
`define DACS_FLD_CHK 2'h3
`define DACS_DCF_BYTES 10
`define DACS_HA_BYTES 4'h5
`define DACS_CNT_BYTES 4'h9
`define DACS_IDX_HEAD 4
`define DACS_IDX_REC 5
`define DACS_IDX_KL 6
`define DACS_IDX_N 9
`define DACS_REC_AFTER_SWITCH 8'h01
`define DACS_N_ALL_DONE 8'hFF
`define DACS_RESET_ADDR 16'h0000

`endif

/* rtl/dacs_pkg.sv */
// types of the disk command sequencer
package dacs_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SEEK, ST_HA, ST_CNT, ST_KD, ST_CHK} dacs_state_t;
endpackage

/* rtl/dacs_top.sv */
// disk attachment command sequencer with ahb-lite register slave
`include "dacs_defines.svh"

module dacs_top #(
  parameter int ADDR_W = 16,
  parameter int LEN_W = 17
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // drive side pins
  input wire logic disk_strobe_i,
  input wire logic [7:0] disk_byte_i,
  input wire logic [1:0] disk_field_i,
  input wire logic disk_index_i,
  input wire logic seek_busy_i,
  input wire logic seek_ack_i,
  output logic seek_req_o,
  output logic [15:0] seek_cyl_o,
  output logic [7:0] seek_head_o,
  // main storage write port
  output logic mem_we_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [7:0] mem_data_o
);

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [13:0] sync1_q, sync2_q;
  logic strobe_d1_q, index_d1_q;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync1_q <= 14'h0000;
      sync2_q <= 14'h0000;
      strobe_d1_q <= 1'b0;
      index_d1_q <= 1'b0;
    end else begin
      sync1_q <= {seek_ack_i, seek_busy_i, disk_index_i, disk_field_i, disk_byte_i, disk_strobe_i};
      sync2_q <= sync1_q;
      strobe_d1_q <= sync2_q[0];
      index_d1_q <= sync2_q[11];
    end
  end
  // byte data settles before its strobe, so the synced copies travel together
  logic byte_ev, index_ev, seek_busy_s, seek_ack_s;
  logic [7:0] byte_s;
  logic [1:0] field_s;
  assign byte_ev = sync2_q[0] & ~strobe_d1_q;
  assign byte_s = sync2_q[8:1];
  assign field_s = sync2_q[10:9];
  assign index_ev = sync2_q[11] & ~index_d1_q;
  assign seek_busy_s = sync2_q[12];
  assign seek_ack_s = sync2_q[13];

  // ***************************************************************
  // ahb-lite address phase capture
  // ***************************************************************
  logic wr_pend_q, rd_pend_q;
  logic [7:0] addr_q;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      if (hready_i) begin
        wr_pend_q <= hsel_i & htrans_i[1] & hwrite_i;
        rd_pend_q <= hsel_i & htrans_i[1] & ~hwrite_i;
        addr_q <= haddr_i[7:0];
      end
    end
  end
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ***************************************************************
  // registers and sequencer
  // ***************************************************************
  dacs_pkg::dacs_state_t state_q;
  logic [2:0] cmd_q;
  logic [7:0] dcf_q [`DACS_DCF_BYTES];
  logic [7:0] cbuf_q [9];
  logic [ADDR_W-1:0] cfa_q, dfa_q, wptr_q;
  logic [3:0] idx_q;
  logic [LEN_W-1:0] left_q;
  logic [7:0] chk_q;
  logic oriented_q, skip_q, capture_q, chk_done_q, refused_q, data_check_q;
  logic busy, cmd_wr, refuse, is_vfy, match, kd_match;
  logic [LEN_W-1:0] len;
  logic [3:0] widx;
  logic [ADDR_W-1:0] start_q;

  assign busy = state_q != dacs_pkg::ST_IDLE;
  assign cmd_wr = wr_pend_q && addr_q == `DACS_OFS_CMD;
  // seek and recalibrate also refused while the drive still moves; this also masks a stale acknowledge
  assign refuse = cmd_wr && (busy || ((hwdata_i[2:0] == `DACS_CMD_SEEK || hwdata_i[2:0] == `DACS_CMD_RECAL) &&
                  seek_busy_s));
  assign is_vfy = cmd_q == `DACS_CMD_VERIFY;
  assign len = LEN_W'(cbuf_q[`DACS_IDX_KL]) + LEN_W'({cbuf_q[7], byte_s});
  // compare against the expected id; count key data looks for the record number minus one first
  assign match = cbuf_q[0] == dcf_q[0] && cbuf_q[1] == dcf_q[1] && cbuf_q[2] == dcf_q[2] &&
                 cbuf_q[3] == dcf_q[3] && cbuf_q[4] == dcf_q[4] &&
                 cbuf_q[5] == (cmd_q == `DACS_CMD_READ_CKD ? dcf_q[5] - 8'h01 : dcf_q[5]);
  assign kd_match = byte_ev && field_s == `DACS_FLD_KD;
  assign widx = 4'(addr_q[7:2] - 6'h04);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= dacs_pkg::ST_IDLE;
      cmd_q <= 3'h0;
      for (int i = 0; i < `DACS_DCF_BYTES; i++) dcf_q[i] <= 8'h00;
      for (int i = 0; i < 9; i++) cbuf_q[i] <= 8'h00;
      cfa_q <= `DACS_RESET_ADDR;
      dfa_q <= `DACS_RESET_ADDR;
      wptr_q <= `DACS_RESET_ADDR;
      start_q <= `DACS_RESET_ADDR;
      idx_q <= 4'h0;
      left_q <= '0;
      chk_q <= 8'h00;
      oriented_q <= 1'b0;
      skip_q <= 1'b0;
      capture_q <= 1'b0;
      chk_done_q <= 1'b0;
      data_check_q <= 1'b0;
      seek_req_o <= 1'b0;
      seek_cyl_o <= 16'h0000;
      seek_head_o <= 8'h00;
      mem_we_o <= 1'b0;
      mem_addr_o <= '0;
      mem_data_o <= 8'h00;
    end else begin
      mem_we_o <= 1'b0;
      // software writes only land while idle; during a command only the sequencer changes the fields
      if (wr_pend_q && !busy) begin
        if (addr_q == `DACS_OFS_CFA) cfa_q <= hwdata_i[ADDR_W-1:0];
        if (addr_q == `DACS_OFS_DFA) dfa_q <= hwdata_i[ADDR_W-1:0];
        if (addr_q >= `DACS_OFS_DCF0 && addr_q <= `DACS_OFS_DCF9) dcf_q[widx] <= hwdata_i[7:0];
      end
      case (state_q)
        dacs_pkg::ST_IDLE: begin
          if (cmd_wr && !refuse) begin
            cmd_q <= hwdata_i[2:0];
            idx_q <= 4'h0;
            oriented_q <= 1'b0;
            capture_q <= 1'b0;
            wptr_q <= dfa_q;
            start_q <= dfa_q;
            data_check_q <= 1'b0;
            case (hwdata_i[2:0])
              `DACS_CMD_SEEK: begin
                seek_req_o <= 1'b1;
                seek_cyl_o <= {dcf_q[1], dcf_q[2]};
                seek_head_o <= dcf_q[`DACS_IDX_HEAD];
                state_q <= dacs_pkg::ST_SEEK;
              end
              `DACS_CMD_RECAL: begin
                seek_req_o <= 1'b1;
                seek_cyl_o <= 16'h0000;
                seek_head_o <= 8'h00;
                state_q <= dacs_pkg::ST_SEEK;
              end
              `DACS_CMD_READ_HA: state_q <= dacs_pkg::ST_HA;
              `DACS_CMD_READ_KD, `DACS_CMD_READ_CKD, `DACS_CMD_VERIFY: state_q <= dacs_pkg::ST_CNT;
              default: state_q <= dacs_pkg::ST_IDLE;
            endcase
          end
        end
        dacs_pkg::ST_SEEK: begin
          // fields and their address registers are never touched by a seek
          if (seek_ack_s) begin
            seek_req_o <= 1'b0;
            state_q <= dacs_pkg::ST_IDLE;
          end
        end
        dacs_pkg::ST_HA: begin
          if (byte_ev && field_s == `DACS_FLD_HA) begin
            dcf_q[idx_q] <= byte_s;
            idx_q <= idx_q + 4'h1;
            if (idx_q == `DACS_HA_BYTES - 4'h1) begin
              idx_q <= 4'h0;
              oriented_q <= 1'b1;
              state_q <= dacs_pkg::ST_CNT;
            end
          end
        end
        dacs_pkg::ST_CNT: begin
          if (index_ev && oriented_q && cmd_q != `DACS_CMD_READ_HA) begin
            // head switch: next track, record zero is bypassed
            dcf_q[`DACS_IDX_HEAD] <= dcf_q[`DACS_IDX_HEAD] + 8'h01;
            dcf_q[`DACS_IDX_REC] <= `DACS_REC_AFTER_SWITCH;
            idx_q <= 4'h0;
          end else if (byte_ev && field_s == `DACS_FLD_CNT) begin
            cbuf_q[idx_q] <= byte_s;
            idx_q <= idx_q + 4'h1;
            if (cmd_q == `DACS_CMD_READ_HA || capture_q) begin
              mem_we_o <= 1'b1;
              mem_addr_o <= wptr_q;
              mem_data_o <= byte_s;
              wptr_q <= wptr_q + ADDR_W'(1);
              if (capture_q) dcf_q[idx_q] <= byte_s;
            end
            if (idx_q == `DACS_CNT_BYTES - 4'h1) begin
              idx_q <= 4'h0;
              left_q <= len;
              chk_q <= 8'h00;
              chk_done_q <= 1'b0;
              state_q <= dacs_pkg::ST_KD;
              if (cmd_q == `DACS_CMD_READ_HA || capture_q) begin
                skip_q <= 1'b0;
              end else if (cmd_q == `DACS_CMD_READ_CKD) begin
                skip_q <= 1'b1;
                capture_q <= match;
              end else begin
                skip_q <= !match;
                oriented_q <= oriented_q | match;
              end
            end
          end
        end
        dacs_pkg::ST_KD: begin
          if (left_q == '0) begin
            if (is_vfy && !skip_q && !chk_done_q) begin
              state_q <= dacs_pkg::ST_CHK;
            end else if (skip_q) begin
              state_q <= dacs_pkg::ST_CNT;
            end else if (cmd_q == `DACS_CMD_READ_HA) begin
              dfa_q <= start_q + ADDR_W'(9);
              state_q <= dacs_pkg::ST_IDLE;
            end else if (cmd_q == `DACS_CMD_READ_CKD) begin
              dfa_q <= wptr_q;
              state_q <= dacs_pkg::ST_IDLE;
            end else if (dcf_q[`DACS_IDX_N] == 8'h00) begin
              dcf_q[`DACS_IDX_N] <= `DACS_N_ALL_DONE;
              if (!is_vfy) dfa_q <= wptr_q;
              state_q <= dacs_pkg::ST_IDLE;
            end else begin
              dcf_q[`DACS_IDX_REC] <= dcf_q[`DACS_IDX_REC] + 8'h01;
              dcf_q[`DACS_IDX_N] <= dcf_q[`DACS_IDX_N] - 8'h01;
              state_q <= dacs_pkg::ST_CNT;
            end
          end else if (kd_match) begin
            left_q <= left_q - LEN_W'(1);
            chk_q <= chk_q ^ byte_s;
            if (!skip_q && !is_vfy) begin
              mem_we_o <= 1'b1;
              mem_addr_o <= wptr_q;
              mem_data_o <= byte_s;
              wptr_q <= wptr_q + ADDR_W'(1);
            end
          end
        end
        dacs_pkg::ST_CHK: begin
          if (byte_ev && field_s == `DACS_FLD_CHK) begin
            if (byte_s == chk_q) begin
              chk_done_q <= 1'b1;
              state_q <= dacs_pkg::ST_KD;
            end else begin
              data_check_q <= 1'b1;
              state_q <= dacs_pkg::ST_IDLE;
            end
          end
        end
        default: state_q <= dacs_pkg::ST_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // refused flag, set wins over clear
  // ***************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) refused_q <= 1'b0;
    else if (refuse) refused_q <= 1'b1;
    else if (wr_pend_q && addr_q == `DACS_OFS_STATUS && hwdata_i[`DACS_ST_REFUSED]) refused_q <= 1'b0;
  end

  // ***************************************************************
  // read data
  // ***************************************************************
  always_comb begin
    hrdata_o = 32'h0000_0000;
    if (rd_pend_q) begin
      if (addr_q == `DACS_OFS_STATUS) begin
        hrdata_o[`DACS_ST_BUSY] = busy;
        hrdata_o[`DACS_ST_SEEK_BUSY] = seek_busy_s;
        hrdata_o[`DACS_ST_REFUSED] = refused_q;
        hrdata_o[`DACS_ST_DATA_CHECK] = data_check_q;
      end else if (addr_q == `DACS_OFS_CMD) hrdata_o[2:0] = cmd_q;
      else if (addr_q == `DACS_OFS_CFA) hrdata_o[ADDR_W-1:0] = cfa_q;
      else if (addr_q == `DACS_OFS_DFA) hrdata_o[ADDR_W-1:0] = dfa_q;
      else if (addr_q >= `DACS_OFS_DCF0 && addr_q <= `DACS_OFS_DCF9) hrdata_o[7:0] = dcf_q[widx];
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  refuse_busy_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_wr && busy |=> $stable(state_q) && refused_q) else $error("command taken while busy");
  seek_busy_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_wr && !busy && hwdata_i[2:0] == `DACS_CMD_SEEK && seek_busy_s |=> !seek_req_o)
    else $error("seek started while drive busy");
  seek_fields_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == dacs_pkg::ST_SEEK |=> $stable(cfa_q) && $stable(dfa_q) && $stable(dcf_q[5]))
    else $error("seek changed a field");
  recal_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    cmd_wr && !refuse && hwdata_i[2:0] == `DACS_CMD_RECAL |=>
    seek_req_o && seek_cyl_o == 16'h0000 && seek_head_o == 8'h00)
    else $error("recalibrate target not zero");
  ha_dfa_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == dacs_pkg::ST_KD && cmd_q == `DACS_CMD_READ_HA && left_q == '0 && !skip_q |=>
    dfa_q == start_q + ADDR_W'(9)) else $error("home read address not start plus 9");
  rec_step_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == dacs_pkg::ST_KD && left_q == '0 && !skip_q && !is_vfy && cmd_q == `DACS_CMD_READ_KD &&
    dcf_q[9] != 8'h00 |=> dcf_q[5] == $past(dcf_q[5]) + 8'h01 && dcf_q[9] == $past(dcf_q[9]) - 8'h01)
    else $error("record or count byte not stepped");
  vfy_no_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    is_vfy && busy |=> !mem_we_o && $stable(dfa_q)) else $error("verify wrote data");
  switch_rec_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == dacs_pkg::ST_CNT && index_ev && oriented_q && cmd_q != `DACS_CMD_READ_HA |=>
    dcf_q[5] == `DACS_REC_AFTER_SWITCH) else $error("head switch did not resume at record 1");
  end_count_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_q == dacs_pkg::ST_KD && left_q == '0 && !skip_q && cmd_q == `DACS_CMD_READ_KD && dcf_q[9] == 8'h00 |=>
    dcf_q[9] == 8'hFF && state_q == dacs_pkg::ST_IDLE) else $error("count not FF at end");

endmodule

/* testbench/dacs_drive_model.sv */
// behavioural disk drive facing the command sequencer
module dacs_drive_model #(
  parameter int SEEK_CYC = 20
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // seek handshake
  input wire logic seek_req_i,
  output logic seek_busy_o,
  output logic seek_ack_o,
  // read stream
  output logic disk_strobe_o,
  output logic [7:0] disk_byte_o,
  output logic [1:0] disk_field_o,
  output logic disk_index_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int seek_cnt;

  initial begin
    seek_busy_o = 1'b0;
    seek_ack_o = 1'b0;
    disk_strobe_o = 1'b0;
    disk_byte_o = 8'h5A;
    disk_field_o = 2'h3;
    disk_index_o = 1'b0;
    seek_cnt = 0;
  end

  // ***************************************************************
  // seek motion
  // ***************************************************************
  always @(posedge mclk_i) begin
    if (rst_i) begin
      seek_cnt <= 0;
      seek_busy_o <= 1'b0;
      seek_ack_o <= 1'b0;
    end else if (seek_req_i && !seek_ack_o) begin
      seek_busy_o <= 1'b1;
      seek_cnt <= seek_cnt + 1;
      if (seek_cnt == SEEK_CYC) begin
        seek_ack_o <= 1'b1;
      end
    end else if (!seek_req_i) begin
      seek_cnt <= 0;
      seek_ack_o <= 1'b0;
      seek_busy_o <= 1'b0;
    end
  end

  // ***************************************************************
  // byte stream tasks
  // ***************************************************************
  task automatic send_byte(input logic [1:0] fld, input logic [7:0] b);
    disk_field_o <= fld;
    disk_byte_o <= b;
    @(posedge mclk_i);
    disk_strobe_o <= 1'b1;
    repeat (3) @(posedge mclk_i);
    disk_strobe_o <= 1'b0;
    @(posedge mclk_i);
    disk_byte_o <= ~b; // released line must not keep the stale byte
    repeat (2) @(posedge mclk_i);
  endtask

  // count area, key/data, then an optional check byte: 1 good, 2 corrupted
  task automatic send_rec(input logic [7:0] h, r, kl, dl, base, input int chk);
    logic [7:0] cnt [9];
    logic [7:0] x;
    cnt = '{8'h00, 8'h00, 8'h2A, 8'h00, h, r, kl, 8'h00, dl};
    x = 8'h00;
    foreach (cnt[i]) send_byte(2'h1, cnt[i]);
    for (int k = 0; k < int'(kl) + int'(dl); k++) begin
      send_byte(2'h2, base + 8'(k));
      x = x ^ (base + 8'(k));
    end
    if (chk == 1) send_byte(2'h3, x);
    if (chk == 2) send_byte(2'h3, ~x);
  endtask

  task automatic pulse_index();
    disk_index_o <= 1'b1;
    repeat (3) @(posedge mclk_i);
    disk_index_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
endmodule

/* testbench/tb.sv */
// self-checking bench for the disk command sequencer
`include "dacs_defines.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, rst_i, hsel_i, hwrite_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, q;
  logic [1:0] htrans_i, disk_field_i;
  logic [2:0] hsize_i;
  logic hreadyout_o, hresp_o, disk_strobe_i, disk_index_i, seek_busy_i, seek_ack_i, seek_req_o, mem_we_o;
  logic [7:0] disk_byte_i, seek_head_o, mem_data_o, last_data;
  logic [15:0] seek_cyl_o, mem_addr_o, last_addr;
  wire hready_i = hreadyout_o;
  int n_mismatch, checks_done, n_we, we0;

  dacs_top u_dacs_top (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .hrdata_o(hrdata_o), .disk_strobe_i(disk_strobe_i), .disk_byte_i(disk_byte_i),
    .disk_field_i(disk_field_i), .disk_index_i(disk_index_i), .seek_busy_i(seek_busy_i), .seek_ack_i(seek_ack_i),
    .seek_req_o(seek_req_o), .seek_cyl_o(seek_cyl_o), .seek_head_o(seek_head_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o));
  dacs_drive_model u_dacs_drive_model (.mclk_i(mclk_i), .rst_i(rst_i), .seek_req_i(seek_req_o),
    .seek_busy_o(seek_busy_i), .seek_ack_o(seek_ack_i), .disk_strobe_o(disk_strobe_i), .disk_byte_o(disk_byte_i),
    .disk_field_o(disk_field_i), .disk_index_o(disk_index_i));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // stores into the data field, counted as they happen
  always @(posedge mclk_i) begin
    if (mem_we_o === 1'b1) begin
      n_we <= n_we + 1;
      last_addr <= mem_addr_o;
      last_data <= mem_data_o;
    end
  end

  // ***************************************************************
  // bus tasks
  // ***************************************************************
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rq);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= wr;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    if (wr) hwdata_i <= d;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rq = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, {24'h0, a}, d, q);
  endtask

  task automatic chkrd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
    ahb(1'b0, {24'h0, a}, 32'h0, q);
    `CHK(nm, ex, q & m)
  endtask

  task automatic set_dcf(input logic [7:0] f [10]);
    for (int i = 0; i < 10; i++) wr(`DACS_OFS_DCF0 + 8'(4 * i), {24'h0, f[i]});
  endtask

  // polls busy; a limited poll so a stuck sequencer is reported, not hung on
  task automatic wait_idle();
    int n;
    n = 0;
    q = 32'h1;
    while (q[`DACS_ST_BUSY] !== 1'b0 && n < 400) begin
      ahb(1'b0, {24'h0, `DACS_OFS_STATUS}, 32'h0, q);
      n++;
    end
    `CHK("busy_release", 1'b0, q[`DACS_ST_BUSY])
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #5000000;
    n_mismatch++;
    complete_run();
  end

  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial begin
    rst_i = 1'b1;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    n_we = 0;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    chkrd("status_reset", `DACS_OFS_STATUS, 32'hF, 32'h0);
    wr(`DACS_OFS_CFA, 32'h40);
    set_dcf('{8'h00, 8'h00, 8'h2A, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    wr(`DACS_OFS_CMD, 32'(`DACS_CMD_SEEK));
    chkrd("seek_busy", `DACS_OFS_STATUS, 32'h5, 32'h1);
    wr(`DACS_OFS_CMD, 32'(`DACS_CMD_SEEK));
    `CHK("seek_cyl", 16'h002A, seek_cyl_o)
    `CHK("seek_head", 8'h07, seek_head_o)
    `CHK("seek_req", 1'b1, seek_req_o)
    wait_idle();
    `CHK("seek_req_drop", 1'b0, seek_req_o)
    chkrd("seek_refused", `DACS_OFS_STATUS, 32'hD, 32'h4);
    chkrd("seek_head_byte", `DACS_OFS_DCF0 + 8'h10, 32'hFF, 32'h07);
    chkrd("seek_cfa", `DACS_OFS_CFA, 32'hFFFF, 32'h40);
    wr(`DACS_OFS_STATUS, 32'h4);
    wr(`DACS_OFS_CMD, 32'(`DACS_CMD_RECAL));
    chkrd("recal_busy", `DACS_OFS_STATUS, 32'h1, 32'h1);
    `CHK("recal_cyl", 16'h0000, seek_cyl_o)
    `CHK("recal_head", 8'h00, seek_head_o)
    wait_idle();
    chkrd("recal_head_byte", `DACS_OFS_DCF0 + 8'h10, 32'hFF, 32'h07);
    // read home address and record zero, with commands pushed at it meanwhile
    wr(`DACS_OFS_DFA, 32'h100);
    wr(`DACS_OFS_CMD, 32'(`DACS_CMD_READ_HA));
    wr(`DACS_OFS_CMD, 32'(`DACS_CMD_READ_KD));
    wr(`DACS_OFS_DFA, 32'h500);
    chkrd("home_busy", `DACS_OFS_STATUS, 32'hD, 32'h5);
    u_dacs_drive_model.send_byte(2'h0, 8'h11);
    u_dacs_drive_model.send_byte(2'h0, 8'h00);
    u_dacs_drive_model.send_byte(2'h0, 8'h2A);
    u_dacs_drive_model.send_byte(2'h0, 8'h00);
    u_dacs_drive_model.send_byte(2'h0, 8'h07);
    u_dacs_drive_model.send_rec(8'h07, 8'h00, 8'h01, 8'h02, 8'h60, 0);
    wait_idle();
    chkrd("home_flag", `DACS_OFS_DCF0, 32'hFF, 32'h11);
    chkrd("home_cyl", `DACS_OFS_DCF0 + 8'h08, 32'hFF, 32'h2A);
    chkrd("home_dfa", `DACS_OFS_DFA, 32'hFFFF, 32'h109);
    `CHK("home_last_byte", 8'h62, last_data)
    wr(`DACS_OFS_STATUS, 32'h4);
    // read key data: one stray record, a head switch, record zero skipped
    set_dcf('{8'h00, 8'h00, 8'h2A, 8'h00, 8'h03, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01});
    wr(`DACS_OFS_DFA, 32'h100);
    we0 = n_we;
    wr(`DACS_OFS_CMD, 32'(`DACS_CMD_READ_KD));
    u_dacs_drive_model.send_rec(8'h03, 8'h04, 8'h01, 8'h01, 8'h40, 0);
    u_dacs_drive_model.send_rec(8'h03, 8'h05, 8'h01, 8'h02, 8'hA0, 0);
    u_dacs_drive_model.pulse_index();
    u_dacs_drive_model.send_rec(8'h04, 8'h00, 8'h01, 8'h01, 8'h50, 0);
    u_dacs_drive_model.send_rec(8'h04, 8'h01, 8'h00, 8'h01, 8'hB0, 0);
    wait_idle();
    chkrd("kd_head", `DACS_OFS_DCF0 + 8'h10, 32'hFF, 32'h04);
    chkrd("kd_record", `DACS_OFS_DCF0 + 8'h14, 32'hFF, 32'h01);
    chkrd("kd_remaining", `DACS_OFS_DCF9, 32'hFF, 32'hFF);
    chkrd("kd_dfa", `DACS_OFS_DFA, 32'hFFFF, 32'h104);
    `CHK("kd_stores", 4, n_we - we0)
    `CHK("kd_last_addr", 16'h0103, last_addr)
    `CHK("kd_last_data", 8'hB0, last_data)
    // read count key data of record 3, oriented on record 2
    set_dcf('{8'h00, 8'h00, 8'h2A, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00});
    wr(`DACS_OFS_DFA, 32'h100);
    wr(`DACS_OFS_CMD, 32'(`DACS_CMD_READ_CKD));
    u_dacs_drive_model.send_rec(8'h03, 8'h02, 8'h01, 8'h01, 8'hC0, 0);
    u_dacs_drive_model.send_rec(8'h03, 8'h03, 8'h02, 8'h01, 8'hD0, 0);
    wait_idle();
    chkrd("ckd_key_len", `DACS_OFS_DCF0 + 8'h18, 32'hFF, 32'h02);
    chkrd("ckd_data_len", `DACS_OFS_DCF0 + 8'h20, 32'hFF, 32'h01);
    chkrd("ckd_dfa", `DACS_OFS_DFA, 32'hFFFF, 32'h10C);
    `CHK("ckd_last_data", 8'hD2, last_data)
    // verify with a sound and then a corrupted check byte
    for (int b = 0; b < 2; b++) begin
      set_dcf('{8'h00, 8'h00, 8'h2A, 8'h00, 8'h03, 8'h07, 8'h00, 8'h00, 8'h00, 8'(1 - b)});
      we0 = n_we;
      wr(`DACS_OFS_CMD, 32'(`DACS_CMD_VERIFY));
      u_dacs_drive_model.send_rec(8'h03, 8'h07, 8'h01, 8'h01, 8'hE0, b + 1);
      // second record lies past a head switch, behind a record zero
      if (b == 0) begin
        u_dacs_drive_model.pulse_index();
        u_dacs_drive_model.send_rec(8'h04, 8'h00, 8'h01, 8'h01, 8'h70, 0);
        u_dacs_drive_model.send_rec(8'h04, 8'h01, 8'h01, 8'h01, 8'hF0, 1);
      end
      wait_idle();
      chkrd("verify_check", `DACS_OFS_STATUS, 32'h8, {28'h0, b[0], 3'h0});
      if (b == 0) chkrd("verify_remaining", `DACS_OFS_DCF9, 32'hFF, 32'hFF);
      if (b == 0) chkrd("verify_record", `DACS_OFS_DCF0 + 8'h14, 32'hFF, 32'h01);
      chkrd("verify_dfa", `DACS_OFS_DFA, 32'hFFFF, 32'h10C);
      `CHK("verify_stores", 0, n_we - we0)
    end
    complete_run();
  end
endmodule
